// [hdl/pin_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
    parameter logic INIT = 1'b1
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // pin and filtered level
    input wire logic pin_i,
    output logic level_o
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // shift chain; the first stage feeds only the second
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // level moves only when the two late stages agree
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            level_o <= INIT;
        end else if (s2_reg == s3_reg) begin
            level_o <= s3_reg;
        end
    end
endmodule

// [hdl/sysctl_core.sv]
// reset cause flags, two-source interrupt unit and option word decode
`timescale 1ns/1ps
module sysctl_core import sysctl_pkg::*; (
    // clock and power-on reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // device pins
    input wire logic ext_reset_n_i,
    input wire logic ext_int_n_i,
    input wire logic pin_change_i,
    // core events
    input wire logic watchdog_timer_expire_i,
    input wire logic timer_counter_ovf_i,
    input wire instr_strobe_t instr_i,
    input wire logic sleep_mode_two_sel_i,
    // interrupt register access
    input wire logic [1:0] flag_clear_i,
    input wire logic mask_wr_i,
    input wire logic [1:0] mask_data_i,
    // option word from one-time storage
    input wire logic [12:0] option_word_i,
    // reset and power status
    output logic core_reset_o,
    output logic wake_o,
    output logic timeout_flag_o,
    output logic powerdown_flag_o,
    output cpu_mode_t cpu_mode_o,
    // interrupt status
    output logic [1:0] irq_req_o,
    output logic [1:0] irq_flag_o,
    output logic gie_o,
    output logic vector_valid_o,
    output logic [11:0] vector_addr_o,
    // decoded options and timer clock tick
    output osc_mode_t osc_mode_o,
    output logic watchdog_en_o,
    output logic cycle_four_o,
    output logic code_protect_o,
    output logic xtal_high_freq_o,
    output logic osc_high_power_o,
    output logic [3:0] programmer_id_o,
    output logic timer_tick_o
);
`include "sysctl_map.svh"

    logic rst_pin_lvl;
    logic int_pin_lvl;
    logic chg_pin_lvl;
    logic rst_pin_prev_reg;
    logic int_pin_prev_reg;
    logic chg_pin_prev_reg;
    logic ext_rst_evt;
    logic int_fall_evt;
    logic chg_evt;
    logic wdt_evt;
    logic wake_evt;
    cpu_mode_t mode_reg;
    logic [1:0] flag_reg;
    logic [1:0] mask_reg;
    logic [1:0] flag_set;
    logic [1:0] pend;
    logic gie_reg;
    logic take_hw;
    logic take_sw;
    logic [12:0] opt_reg;
    logic opt_loaded_reg;
    logic [1:0] div_cnt_reg;
    logic [1:0] div_last;

    // pin synchronisers
    pin_sync #(.INIT(1'b1)) u_rst_sync (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .pin_i(ext_reset_n_i),
        .level_o(rst_pin_lvl)
    );
    pin_sync #(.INIT(1'b1)) u_int_sync (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .pin_i(ext_int_n_i),
        .level_o(int_pin_lvl)
    );
    pin_sync #(.INIT(1'b0)) u_chg_sync (
        .clk_sys_i(clk_sys_i),
        .nrst_i(nrst_i),
        .pin_i(pin_change_i),
        .level_o(chg_pin_lvl)
    );

    // previous filtered levels for edge detection
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_pin_prev_reg <= 1'b1;
            int_pin_prev_reg <= 1'b1;
            chg_pin_prev_reg <= 1'b0;
        end else begin
            rst_pin_prev_reg <= rst_pin_lvl;
            int_pin_prev_reg <= int_pin_lvl;
            chg_pin_prev_reg <= chg_pin_lvl;
        end
    end

    // reset causes and wake events
    assign ext_rst_evt = rst_pin_lvl & ~rst_pin_prev_reg;
    assign wdt_evt = watchdog_timer_expire_i & watchdog_en_o;
    assign chg_evt = chg_pin_lvl ^ chg_pin_prev_reg;
    assign wake_evt = chg_evt & (mode_reg == MODE_SLEEP_TWO);
    assign int_fall_evt = ~int_pin_lvl & int_pin_prev_reg;

    // time-out and power-down flags, power mode
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timeout_flag_o <= 1'b1;
            powerdown_flag_o <= 1'b1;
            mode_reg <= MODE_OPERATING;
        end else if (ext_rst_evt) begin
            if (mode_reg == MODE_SLEEP_ONE) begin
                timeout_flag_o <= 1'b1;
                powerdown_flag_o <= 1'b0;
            end
            mode_reg <= MODE_OPERATING;
        end else if (wdt_evt) begin
            timeout_flag_o <= 1'b0;
            if (mode_reg == MODE_SLEEP_ONE) begin
                powerdown_flag_o <= 1'b0;
            end
            mode_reg <= MODE_OPERATING;
        end else if (wake_evt) begin
            mode_reg <= MODE_OPERATING;
        end else if (mode_reg == MODE_OPERATING) begin
            if (instr_i.watchdog_clear_instr) begin
                timeout_flag_o <= 1'b1;
                powerdown_flag_o <= 1'b1;
            end else if (instr_i.sleep_instr) begin
                timeout_flag_o <= 1'b1;
                powerdown_flag_o <= 1'b0;
                if (sleep_mode_two_sel_i) begin
                    mode_reg <= MODE_SLEEP_TWO;
                end else begin
                    mode_reg <= MODE_SLEEP_ONE;
                end
            end
        end
    end

    // core reset and wake pulses
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            core_reset_o <= 1'b1;
            wake_o <= 1'b0;
        end else begin
            core_reset_o <= ext_rst_evt | wdt_evt;
            wake_o <= wake_evt;
        end
    end

    always_comb cpu_mode_o = mode_reg;

    // interrupt source flags; a set beats a clear in the same cycle
    always_comb begin
        flag_set = 2'h0;
        flag_set[`IRQ_TIMER_BIT] = timer_counter_ovf_i;
        flag_set[`IRQ_EXT_BIT] = int_fall_evt;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            flag_reg <= `FLAG_RESET;
        end else begin
            flag_reg <= (flag_reg & ~flag_clear_i) | flag_set;
        end
    end

    // interrupt mask register
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mask_reg <= `MASK_RESET;
        end else if (mask_wr_i) begin
            mask_reg <= mask_data_i;
        end
    end

    assign pend = flag_reg & mask_reg;
    assign take_hw = gie_reg & (|pend) & ~core_reset_o;
    assign take_sw = gie_reg & instr_i.soft_int_instr & ~take_hw & ~core_reset_o;

    // request and flag outputs
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_req_o <= 2'h0;
            irq_flag_o <= 2'h0;
        end else begin
            irq_req_o <= pend;
            irq_flag_o <= flag_reg;
        end
    end

    // global interrupt enable; entry clears it to stop re-entry
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gie_reg <= 1'b0;
        end else if (ext_rst_evt | wdt_evt) begin
            gie_reg <= 1'b0;
        end else if (take_hw | take_sw) begin
            gie_reg <= 1'b0;
        end else if (instr_i.global_int_enable_instr) begin
            gie_reg <= 1'b1;
        end else if (instr_i.return_from_isr_instr) begin
            gie_reg <= 1'b1;
        end else if (instr_i.global_int_disable_instr) begin
            gie_reg <= 1'b0;
        end
    end

    always_comb gie_o = gie_reg;

    // vector fetch request
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            vector_valid_o <= 1'b0;
            vector_addr_o <= `VEC_RST_ADDR;
        end else begin
            vector_valid_o <= take_hw | take_sw;
            if (take_hw) begin
                vector_addr_o <= `VEC_HW_ADDR;
            end else if (take_sw) begin
                vector_addr_o <= `VEC_SW_ADDR;
            end
        end
    end

    // option word captured once after reset release; no program path to it
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            opt_reg <= `OPT_RESET;
            opt_loaded_reg <= 1'b0;
        end else if (!opt_loaded_reg) begin
            opt_reg <= option_word_i;
            opt_loaded_reg <= 1'b1;
        end
    end

    // option decode
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            osc_mode_o <= RC_OSC_MODE;
            watchdog_en_o <= 1'b0;
            cycle_four_o <= 1'b0;
            code_protect_o <= 1'b1;
            xtal_high_freq_o <= 1'b0;
            osc_high_power_o <= 1'b0;
            programmer_id_o <= 4'h0;
        end else begin
            if (!opt_reg[`OPT_OSC_TYPE_BIT]) begin
                osc_mode_o <= RC_OSC_MODE;
            end else if (opt_reg[`OPT_XTAL_FREQ_BIT]) begin
                osc_mode_o <= HIGH_XTAL_MODE;
            end else begin
                osc_mode_o <= LOW_XTAL_MODE;
            end
            watchdog_en_o <= ~opt_reg[`OPT_WDT_OFF_BIT];
            cycle_four_o <= opt_reg[`OPT_CYCLE_BIT];
            code_protect_o <= ~opt_reg[`OPT_SECURITY_BIT];
            xtal_high_freq_o <= opt_reg[`OPT_OSC_TYPE_BIT] & opt_reg[`OPT_XTAL_FREQ_BIT];
            osc_high_power_o <= opt_reg[`OPT_OSC_POWER_BIT];
            programmer_id_o <= opt_reg[`OPT_ID_MSB:`OPT_ID_LSB];
        end
    end

    // timer clock divider, by two or by four
    assign div_last = cycle_four_o ? `TDIV_FOUR_LAST : `TDIV_TWO_LAST;

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_cnt_reg <= 2'h0;
            timer_tick_o <= 1'b0;
        end else begin
            if (div_cnt_reg >= div_last) begin
                div_cnt_reg <= 2'h0;
            end else begin
                div_cnt_reg <= div_cnt_reg + 2'h1;
            end
            timer_tick_o <= (div_cnt_reg >= div_last);
        end
    end

    // checks
    property p_wdt_clears_t;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wdt_evt && !ext_rst_evt) |=> !timeout_flag_o && core_reset_o;
    endproperty
    a_wdt_clears_t: assert property (p_wdt_clears_t) else $error("wdt kept T");

    property p_wdt_sleep_one;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wdt_evt && !ext_rst_evt && mode_reg == MODE_SLEEP_ONE)
            |=> !powerdown_flag_o && mode_reg == MODE_OPERATING;
    endproperty
    a_wdt_sleep_one: assert property (p_wdt_sleep_one) else $error("wdt sleep_mode_one P");

    property p_ext_awake;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (ext_rst_evt && mode_reg != MODE_SLEEP_ONE)
            |=> $stable(timeout_flag_o) && $stable(powerdown_flag_o);
    endproperty
    a_ext_awake: assert property (p_ext_awake) else $error("pin reset changed flags");

    property p_ext_sleep_one;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (ext_rst_evt && mode_reg == MODE_SLEEP_ONE) |=> timeout_flag_o && !powerdown_flag_o;
    endproperty
    a_ext_sleep_one: assert property (p_ext_sleep_one) else $error("pin wake sleep_mode_one flags");

    property p_pin_wake;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (wake_evt && !ext_rst_evt && !wdt_evt)
            |=> $stable(timeout_flag_o) && $stable(powerdown_flag_o) ##1 wake_o == 1'b0;
    endproperty
    a_pin_wake: assert property (p_pin_wake) else $error("pin wake changed flags");

    property p_sleep_instr;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (instr_i.sleep_instr && !instr_i.watchdog_clear_instr && mode_reg == MODE_OPERATING
            && !ext_rst_evt && !wdt_evt) |=> timeout_flag_o && !powerdown_flag_o
            && mode_reg != MODE_OPERATING;
    endproperty
    a_sleep_instr: assert property (p_sleep_instr) else $error("sleep flags wrong");

    property p_flag_quiet;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (!ext_rst_evt && !wdt_evt && !instr_i.sleep_instr && !instr_i.watchdog_clear_instr)
            |=> $stable(timeout_flag_o) && $stable(powerdown_flag_o);
    endproperty
    a_flag_quiet: assert property (p_flag_quiet) else $error("flag moved alone");

    property p_flag_set;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        timer_counter_ovf_i |=> flag_reg[`IRQ_TIMER_BIT] ##1 irq_flag_o[`IRQ_TIMER_BIT];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("timer flag not set");

    property p_irq_and;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        1'b1 |=> irq_req_o == ($past(flag_reg) & $past(mask_reg));
    endproperty
    a_irq_and: assert property (p_irq_and) else $error("request not flag and mask");

    property p_hw_vector;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        take_hw |=> vector_valid_o && vector_addr_o == 12'h001 && !gie_reg;
    endproperty
    a_hw_vector: assert property (p_hw_vector) else $error("hw vector wrong");

    property p_sw_vector;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (gie_reg && instr_i.soft_int_instr && pend == 2'h0 && !core_reset_o)
            |=> vector_valid_o && vector_addr_o == 12'h002;
    endproperty
    a_sw_vector: assert property (p_sw_vector) else $error("sw vector wrong");

    property p_return_from_isr_instr;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        ((instr_i.return_from_isr_instr || instr_i.global_int_enable_instr) && !take_hw
            && !take_sw && !ext_rst_evt && !wdt_evt) |=> gie_reg;
    endproperty
    a_return_from_isr_instr: assert property (p_return_from_isr_instr) else $error("enable not set");

    property p_div_four;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        (timer_tick_o && cycle_four_o && $past(cycle_four_o, 2)) |=> !timer_tick_o [*3] ##1 timer_tick_o;
    endproperty
    a_div_four: assert property (p_div_four) else $error("timer divide not four");

    property p_wdt_option;
        @(posedge clk_sys_i) disable iff (!nrst_i)
        opt_loaded_reg |=> watchdog_en_o == !$past(opt_reg[`OPT_WDT_OFF_BIT]);
    endproperty
    a_wdt_option: assert property (p_wdt_option) else $error("watchdog enable wrong");

    c_hw_int: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) take_hw);
    c_sw_int: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) take_sw);
    c_sleep_wake: cover property (@(posedge clk_sys_i) disable iff (!nrst_i) wake_evt);
    c_wdt_s1: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
        wdt_evt && mode_reg == MODE_SLEEP_ONE);
endmodule

// [hdl/sysctl_map.svh]
// option field positions, vectors and reset values of the system control block
`ifndef SYSCTL_MAP_SVH
`define SYSCTL_MAP_SVH

// option word field positions
`define OPT_WIDTH 13
`define OPT_OSC_TYPE_BIT 12
`define OPT_WDT_OFF_BIT 11
`define OPT_CYCLE_BIT 10
`define OPT_SECURITY_BIT 9
`define OPT_XTAL_FREQ_BIT 8
`define OPT_OSC_POWER_BIT 7
`define OPT_ID_MSB 3
`define OPT_ID_LSB 0

// program addresses for interrupt entry, and the vector address loaded at reset
`define VEC_HW_ADDR 12'h001
`define VEC_SW_ADDR 12'h002
`define VEC_RST_ADDR 12'h000

// interrupt flag positions
`define IRQ_TIMER_BIT 0
`define IRQ_EXT_BIT 1

// timer clock divider terminal counts (divide by 2 and by 4)
`define TDIV_TWO_LAST 2'h1
`define TDIV_FOUR_LAST 2'h3

// reset values
`define OPT_RESET 13'h0000
`define MASK_RESET 2'h0
`define FLAG_RESET 2'h0

`endif

// [hdl/sysctl_pkg.sv]
// types shared by the system control block
package sysctl_pkg;
    // processor power mode
    typedef enum logic [1:0] {
        MODE_OPERATING,
        MODE_SLEEP_ONE,
        MODE_SLEEP_TWO
    } cpu_mode_t;

    // oscillator mode decoded from the option word
    typedef enum logic [1:0] {
        RC_OSC_MODE,
        HIGH_XTAL_MODE,
        LOW_XTAL_MODE
    } osc_mode_t;

    // one-cycle instruction strobes from the core decoder
    typedef struct packed {
        logic global_int_enable_instr;
        logic global_int_disable_instr;
        logic return_from_isr_instr;
        logic soft_int_instr;
        logic watchdog_clear_instr;
        logic sleep_instr;
    } instr_strobe_t;
endpackage

// [tb/ext_pins_model.sv]
// model of the external reset circuit, interrupt pin and wake-up pin
`timescale 1ns/1ps
module ext_pins_model (
    // clock
    input wire logic clk_sys_i,
    // driven pins
    output logic ext_reset_n_o,
    output logic ext_int_n_o,
    output logic pin_change_o
);
    // idle levels: pulled-up reset and interrupt pins, wake pin low
    initial begin
        ext_reset_n_o = 1'b1;
        ext_int_n_o = 1'b1;
        pin_change_o = 1'b0;
    end
    // high-low-high pulse, long enough for the pin filter
    task automatic reset_pulse();
        @(posedge clk_sys_i);
        ext_reset_n_o <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        ext_reset_n_o <= 1'b1;
    endtask
    // falling request, then back to idle
    task automatic int_pulse();
        @(posedge clk_sys_i);
        ext_int_n_o <= 1'b0;
        repeat (6) @(posedge clk_sys_i);
        ext_int_n_o <= 1'b1;
        repeat (6) @(posedge clk_sys_i);
    endtask
    // one level change on the wake-up pin
    task automatic change_pin();
        @(posedge clk_sys_i);
        pin_change_o <= ~pin_change_o;
    endtask
endmodule

// [tb/test_reset_cause_interrupt_option_ctrl.sv]
// self-checking bench of the system control block
`timescale 1ns/1ps
module test_reset_cause_interrupt_option_ctrl import sysctl_pkg::*; ;
    logic clk_sys_i = 1'b0;
    logic nrst_i, wdt_exp, ovf, sleep_two, mask_wr;
    logic [1:0] flag_clr, mask_data;
    logic [12:0] opt;
    instr_strobe_t instr;
    wire logic ext_reset_n, ext_int_n, pin_change;
    logic core_reset_o, wake_o, timeout_flag_o, powerdown_flag_o, gie_o, vector_valid_o;
    logic watchdog_en_o, cycle_four_o, code_protect_o, xtal_high_freq_o;
    logic osc_high_power_o, timer_tick_o;
    logic [1:0] irq_req_o, irq_flag_o;
    logic [3:0] programmer_id_o, cnt;
    logic [11:0] vector_addr_o, last_vec;
    cpu_mode_t cpu_mode_o;
    osc_mode_t osc_mode_o;
    int error_cnt = 0;
    int n_compared = 0;
    int n_rst, n_wake, n_vec;
    wire logic [1:0] tp = {timeout_flag_o, powerdown_flag_o};
    wire logic [10:0] dec = {osc_mode_o, watchdog_en_o, cycle_four_o, code_protect_o,
        xtal_high_freq_o, osc_high_power_o, programmer_id_o};
    // option word beside the decode it should give, RC rows keep bit 8 low
    logic [23:0] rows [5] = '{{13'h0000, 11'h140}, {13'h1FFF, 11'h2BF},
        {13'h1005, 11'h545}, {13'h0E8A, 11'h09A}, {13'h1480, 11'h5D0}};

    always #50 clk_sys_i = ~clk_sys_i;

    // far side pins
    ext_pins_model pins (.clk_sys_i(clk_sys_i), .ext_reset_n_o(ext_reset_n),
        .ext_int_n_o(ext_int_n), .pin_change_o(pin_change));

    sysctl_core DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ext_reset_n_i(ext_reset_n),
        .ext_int_n_i(ext_int_n), .pin_change_i(pin_change),
        .watchdog_timer_expire_i(wdt_exp), .timer_counter_ovf_i(ovf), .instr_i(instr),
        .sleep_mode_two_sel_i(sleep_two), .flag_clear_i(flag_clr), .mask_wr_i(mask_wr),
        .mask_data_i(mask_data), .option_word_i(opt), .core_reset_o(core_reset_o),
        .wake_o(wake_o), .timeout_flag_o(timeout_flag_o),
        .powerdown_flag_o(powerdown_flag_o), .cpu_mode_o(cpu_mode_o),
        .irq_req_o(irq_req_o), .irq_flag_o(irq_flag_o), .gie_o(gie_o),
        .vector_valid_o(vector_valid_o), .vector_addr_o(vector_addr_o),
        .osc_mode_o(osc_mode_o), .watchdog_en_o(watchdog_en_o),
        .cycle_four_o(cycle_four_o), .code_protect_o(code_protect_o),
        .xtal_high_freq_o(xtal_high_freq_o), .osc_high_power_o(osc_high_power_o),
        .programmer_id_o(programmer_id_o), .timer_tick_o(timer_tick_o));

    // count one-cycle pulses outside power-on reset
    always @(negedge clk_sys_i) begin
        if (nrst_i === 1'b1 && core_reset_o === 1'b1) n_rst++;
        if (wake_o === 1'b1) n_wake++;
        if (vector_valid_o === 1'b1) begin
            n_vec++;
            last_vec = vector_addr_o;
        end
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string m);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    // flags and pulse counts since the last call
    task automatic ev_chk(input logic [1:0] f, input int r, w, v, input string m);
        chk(tp, f, m);
        chk(n_rst, r, m);
        chk(n_wake, w, m);
        chk(n_vec, v, m);
        n_rst = 0;
        n_wake = 0;
        n_vec = 0;
    endtask

    task automatic por(input logic [12:0] o);
        @(posedge clk_sys_i);
        nrst_i <= 1'b0;
        opt <= o;
        repeat (8) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        chk({core_reset_o, gie_o, irq_flag_o, tp}, 6'h23, "reset state");
        @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (3) @(negedge clk_sys_i);
        n_rst = 0;
        n_wake = 0;
        n_vec = 0;
    endtask

    task automatic strobe(input logic [5:0] s);
        @(posedge clk_sys_i);
        instr <= instr_strobe_t'(s);
        @(posedge clk_sys_i);
        instr <= instr_strobe_t'(6'h00);
        repeat (3) @(negedge clk_sys_i);
    endtask

    // 0 watchdog expiry, 1 timer overflow, 2 flag clear, 3 mask write
    task automatic pulse_in(input int w, input logic [1:0] d);
        @(posedge clk_sys_i);
        case (w)
            0: wdt_exp <= 1'b1;
            1: ovf <= 1'b1;
            2: flag_clr <= d;
            default: begin
                mask_wr <= 1'b1;
                mask_data <= d;
            end
        endcase
        @(posedge clk_sys_i);
        wdt_exp <= 1'b0;
        ovf <= 1'b0;
        flag_clr <= 2'h0;
        mask_wr <= 1'b0;
        repeat (4) @(negedge clk_sys_i);
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (4000) @(posedge clk_sys_i);
        error_cnt++;
        final_report();
    end

    initial begin
        nrst_i = 1'b0;
        wdt_exp = 1'b0;
        ovf = 1'b0;
        sleep_two = 1'b0;
        mask_wr = 1'b0;
        flag_clr = 2'h0;
        mask_data = 2'h0;
        opt = 13'h0000;
        instr = instr_strobe_t'(6'h00);
        // option decode and timer clock per row
        for (int i = 0; i < 5; i++) begin
            por(rows[i][23:11]);
            chk(tp, 2'h3, "power-on flags");
            chk(dec, rows[i][10:0], "option decode");
            cnt = 4'h0;
            repeat (8) begin
                @(negedge clk_sys_i);
                cnt = cnt + timer_tick_o;
            end
            chk(cnt, rows[i][21] ? 4'h2 : 4'h4, "tick rate");
            // watchdog expiry only acts when the option enables it
            pulse_in(0, 2'h0);
            ev_chk(rows[i][22] ? 2'h3 : 2'h1, !rows[i][22], 0, 0, "watchdog option");
        end
        // reset cause flags, watchdog enabled
        por(13'h0000);
        pins.reset_pulse();
        repeat (8) @(negedge clk_sys_i);
        ev_chk(2'h3, 1, 0, 0, "pin reset operating");
        strobe(6'h01);
        chk(cpu_mode_o, MODE_SLEEP_ONE, "sleep one entry");
        ev_chk(2'h2, 0, 0, 0, "sleep");
        pulse_in(0, 2'h0);
        ev_chk(2'h0, 1, 0, 0, "watchdog sleep one");
        chk(cpu_mode_o, MODE_OPERATING, "watchdog wake");
        strobe(6'h02);
        ev_chk(2'h3, 0, 0, 0, "watchdog clear");
        pulse_in(0, 2'h0);
        ev_chk(2'h1, 1, 0, 0, "watchdog operating");
        strobe(6'h01);
        pins.reset_pulse();
        repeat (8) @(negedge clk_sys_i);
        ev_chk(2'h2, 1, 0, 0, "pin reset sleep one");
        chk(cpu_mode_o, MODE_OPERATING, "pin wake");
        @(posedge clk_sys_i);
        sleep_two <= 1'b1;
        strobe(6'h01);
        chk(cpu_mode_o, MODE_SLEEP_TWO, "sleep two entry");
        pins.change_pin();
        repeat (8) @(negedge clk_sys_i);
        ev_chk(2'h2, 0, 1, 0, "pin change wake");
        chk(cpu_mode_o, MODE_OPERATING, "change wake mode");
        // interrupts
        strobe(6'h20);
        chk(gie_o, 1'b1, "enable");
        pulse_in(1, 2'h0);
        chk({irq_flag_o, irq_req_o}, 4'h4, "masked overflow");
        pulse_in(3, 2'h1);
        ev_chk(2'h2, 0, 0, 1, "hardware vector");
        chk({last_vec, gie_o, irq_req_o}, 15'h0009, "hardware entry");
        pulse_in(2, 2'h1);
        strobe(6'h08);
        chk(gie_o, 1'b1, "return enables");
        ev_chk(2'h2, 0, 0, 0, "no re-entry");
        strobe(6'h04);
        ev_chk(2'h2, 0, 0, 1, "software vector");
        chk(last_vec, 12'h002, "software address");
        pins.int_pulse();
        @(negedge clk_sys_i);
        chk({irq_flag_o, irq_req_o}, 4'h8, "pin request masked");
        strobe(6'h20);
        strobe(6'h10);
        chk(gie_o, 1'b0, "disable");
        ev_chk(2'h2, 0, 0, 0, "masked pin no vector");
        final_report();
    end
endmodule
